//--- core/memory_location_sequencer.sv
`timescale 1ns/100ps
// How it works
// - Reset selects location 1.
// - One hundred locations, numbered 1 to 100.
// - Each location holds voltage, current, dwell, modulation and sink flag.
// - Dwell 20 ms to 1000 s, 1 ms steps, whole seconds in top range.
// - Advancing onto a zero-dwell location goes to location 1 instead.
// - Single step: each start advances; run light lasts that dwell.
// - Single step at last programmed location returns to location 1.
// - Single cycle starts at next location, holds each for its dwell.
// - Single cycle ends, light off, when last location's dwell expires.
// - Continuous wraps to location 1 until stopped or mode changes.
// - A start while continuous runs halts at the present location.
// - Resuming a halted sequence begins at the following location.
// - Starts come from run key, external trigger or bus command.
// - Bus picks mode with one of three codes, then a trigger.
// - With talk start enabled, being addressed to talk starts the mode.
// - Modulation selection per location, voltage or current, with indicators.
// - Sink selection per location lights sink indicator; cleared means source.
// - Continuous key sets continuous mode without starting.
// - Setpoints reach the outputs only while operate is on.
// - Source quadrant shown when voltage and current signs agree.
// - Active location chosen by entering its number.
// - Location storage has no reset and keeps its contents.
module memory_location_sequencer
  import seq_pkg::*;
#(
  parameter int TICK_CYCLES_P     = TICK_CYCLES,
  parameter int DEBOUNCE_CYCLES_P = DEBOUNCE_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        WR_STROBE,
  input  wire logic        RD_STROBE,
  output logic      [31:0] RD_DATA,
  input  wire logic        RUN_KEY,
  input  wire logic        EXT_TRIGGER,
  input  wire logic        TALK_ADDRESSED,
  input  wire logic        V_NEGATIVE,
  input  wire logic        I_NEGATIVE,
  output logic      [15:0] VOLTAGE_OUT,
  output logic      [15:0] CURRENT_OUT,
  output logic             MOD_V_LED,
  output logic             MOD_I_LED,
  output logic             SINK_LED,
  output logic             RUN_LED,
  output logic             SOURCE_QUADRANT,
  output logic      [6:0]  ACTIVE_LOCATION
);

  location_type mem [LOC_COUNT];
  location_type cur;
  mode_type     mode;
  mode_type     next_mode;
  state_type    state;
  logic [6:0]   loc;
  logic [6:0]   succ;
  logic [6:0]   next_loc;
  logic         operate;
  logic         talk_start_trigger;
  logic         key_meta, key_sync, key_stable, key_pulse;
  logic [31:0]  key_count;
  logic         trig_meta, trig_sync, trig_prev;
  logic         talk_meta, talk_sync, talk_prev;
  logic         vneg_meta, vneg_sync, ineg_meta, ineg_sync;
  logic [31:0]  tick_count;
  logic [19:0]  ms_count;
  logic         w_mode, w_loc, cmd_run, cmd_cont, start_event;
  logic         mode_switch, last_loc, expire, advance, halt;

  function automatic logic [6:0] bump(input logic [6:0] l);
    return (l == LOC_LAST) ? LOC_FIRST : 7'(l + 7'h01);
  endfunction

  function automatic logic [19:0] dwell_fit(input logic [31:0] v);
    logic [31:0] r;
    r = v;
    if (v != 32'h0 && v < 32'(DWELL_MIN_MS)) r = 32'(DWELL_MIN_MS);
    if (v > 32'(DWELL_MAX_MS)) r = 32'(DWELL_MAX_MS);
    if (r >= 32'(DWELL_COARSE_MS)) r = r - (r % 32'(DWELL_COARSE_STEP_MS));
    return r[19:0];
  endfunction

  // Bus decode
  assign w_mode   = WR_STROBE && ADDR == ADDR_MODE;
  assign w_loc    = WR_STROBE && ADDR == ADDR_LOC;
  assign cmd_run  = WR_STROBE && ADDR == ADDR_CMD && WR_DATA[CMD_RUN];
  assign cmd_cont = WR_STROBE && ADDR == ADDR_CMD && WR_DATA[CMD_CONT];

  always_comb begin
    next_mode = mode;
    if (w_mode && WR_DATA[1:0] != 2'h3) begin
      next_mode = mode_type'(WR_DATA[1:0]);
    end else if (cmd_cont) begin
      next_mode = sequence_mode_code_c;
    end
  end

  assign mode_switch = next_mode != mode;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode               <= sequence_mode_code_a;
      operate            <= 1'b0;
      talk_start_trigger <= 1'b0;
    end else begin
      mode <= next_mode;
      if (w_mode) begin
        operate            <= WR_DATA[MODE_OPERATE];
        talk_start_trigger <= WR_DATA[MODE_TALK];
      end
    end
  end

  // Input synchronisers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      key_meta  <= 1'b0;
      key_sync  <= 1'b0;
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
      talk_meta <= 1'b0;
      talk_sync <= 1'b0;
      talk_prev <= 1'b0;
      vneg_meta <= 1'b0;
      vneg_sync <= 1'b0;
      ineg_meta <= 1'b0;
      ineg_sync <= 1'b0;
    end else begin
      key_meta  <= RUN_KEY;
      key_sync  <= key_meta;
      trig_meta <= EXT_TRIGGER;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
      talk_meta <= TALK_ADDRESSED;
      talk_sync <= talk_meta;
      talk_prev <= talk_sync;
      vneg_meta <= V_NEGATIVE;
      vneg_sync <= vneg_meta;
      ineg_meta <= I_NEGATIVE;
      ineg_sync <= ineg_meta;
    end
  end

  // Key must hold its new level for the whole debounce time
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      key_stable <= 1'b0;
      key_count  <= 32'h0;
      key_pulse  <= 1'b0;
    end else begin
      key_pulse <= 1'b0;
      if (key_sync == key_stable) begin
        key_count <= 32'h0;
      end else if (key_count >= 32'(DEBOUNCE_CYCLES_P - 1)) begin
        key_count  <= 32'h0;
        key_stable <= key_sync;
        key_pulse  <= key_sync;
      end else begin
        key_count <= key_count + 32'h1;
      end
    end
  end

  assign start_event = key_pulse || (trig_sync && !trig_prev) || cmd_run
                     || (talk_start_trigger && talk_sync && !talk_prev);

  // Location storage keeps its contents through reset
  always_ff @(posedge CLK) begin
    if (WR_STROBE) begin
      case (ADDR)
        ADDR_VOLT:  mem[loc - 7'h01].voltage <= WR_DATA[15:0];
        ADDR_CURR:  mem[loc - 7'h01].current <= WR_DATA[15:0];
        ADDR_DWELL: mem[loc - 7'h01].dwell   <= dwell_fit(WR_DATA);
        ADDR_FLAGS: begin
          mem[loc - 7'h01].mod_v <= WR_DATA[FLAG_MOD_V];
          mem[loc - 7'h01].mod_i <= WR_DATA[FLAG_MOD_I] && !WR_DATA[FLAG_MOD_V];
          mem[loc - 7'h01].sink  <= WR_DATA[FLAG_SINK];
        end
        default: ;
      endcase
    end
  end

  assign cur      = mem[loc - 7'h01];
  assign succ     = bump(loc);
  assign next_loc = (mem[succ - 7'h01].dwell == 20'h0) ? LOC_FIRST : succ;
  assign last_loc = next_loc == LOC_FIRST;
  assign expire   = ms_count >= cur.dwell;

  assign advance = !mode_switch && (((state == seq_idle || state == seq_step) && start_event)
                 || (state == seq_run && !start_event && expire
                     && !(mode == sequence_mode_code_b && last_loc)));
  assign halt    = mode_switch || (state == seq_step && expire)
                 || (state == seq_run && (start_event || expire));

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= seq_idle;
      loc   <= LOC_FIRST;
    end else if (advance) begin
      loc <= next_loc;
      if (state == seq_idle) begin
        state <= (mode == sequence_mode_code_a) ? seq_step : seq_run;
      end
    end else begin
      case (state)
        seq_idle: begin
          if (w_loc && WR_DATA != 32'h0 && WR_DATA <= 32'(LOC_COUNT)) begin
            loc <= WR_DATA[6:0];
          end
        end
        seq_step, seq_run: begin
          if (halt) begin
            state <= seq_idle;
          end
        end
        default: state <= seq_idle;
      endcase
    end
  end

  // Dwell timer restarts on each new location
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_count <= 32'h0;
      ms_count   <= 20'h0;
    end else if (advance || state == seq_idle) begin
      tick_count <= 32'h0;
      ms_count   <= 20'h0;
    end else if (tick_count >= 32'(TICK_CYCLES_P - 1)) begin
      tick_count <= 32'h0;
      if (ms_count != 20'hFFFFF) begin
        ms_count <= ms_count + 20'h1;
      end
    end else begin
      tick_count <= tick_count + 32'h1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      VOLTAGE_OUT     <= 16'h0;
      CURRENT_OUT     <= 16'h0;
      MOD_V_LED       <= 1'b0;
      MOD_I_LED       <= 1'b0;
      SINK_LED        <= 1'b0;
      RUN_LED         <= 1'b0;
      SOURCE_QUADRANT <= 1'b1;
      ACTIVE_LOCATION <= LOC_FIRST;
    end else begin
      VOLTAGE_OUT     <= operate ? cur.voltage : 16'h0;
      CURRENT_OUT     <= operate ? cur.current : 16'h0;
      MOD_V_LED       <= cur.mod_v;
      MOD_I_LED       <= cur.mod_i;
      SINK_LED        <= cur.sink;
      RUN_LED         <= state != seq_idle;
      SOURCE_QUADRANT <= vneg_sync == ineg_sync;
      ACTIVE_LOCATION <= loc;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RD_DATA <= 32'h0;
    end else if (RD_STROBE) begin
      case (ADDR)
        ADDR_MODE:   RD_DATA <= {28'h0, talk_start_trigger, operate, mode};
        ADDR_LOC:    RD_DATA <= {25'h0, loc};
        ADDR_VOLT:   RD_DATA <= {{16{cur.voltage[15]}}, cur.voltage};
        ADDR_CURR:   RD_DATA <= {{16{cur.current[15]}}, cur.current};
        ADDR_DWELL:  RD_DATA <= {12'h0, cur.dwell};
        ADDR_FLAGS:  RD_DATA <= {29'h0, cur.sink, cur.mod_i, cur.mod_v};
        ADDR_STATUS: RD_DATA <= {26'h0, state, SOURCE_QUADRANT, RUN_LED, state != seq_idle};
        default:     RD_DATA <= 32'h0;
      endcase
    end else begin
      RD_DATA <= 32'h0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_reset_loc;
    $past(SYS_RST) |-> ACTIVE_LOCATION == LOC_FIRST && loc == LOC_FIRST;
  endproperty
  a_reset_loc: assert property (p_reset_loc) else $error("location not 1 after reset");

  property p_loc_range;
    loc >= LOC_FIRST && loc <= LOC_LAST;
  endproperty
  a_loc_range: assert property (p_loc_range) else $error("location out of range");

  property p_zero_wrap;
    advance && mem[succ - 7'h01].dwell == 20'h0 |=> loc == LOC_FIRST;
  endproperty
  a_zero_wrap: assert property (p_zero_wrap) else $error("zero dwell not wrapped");

  property p_step_led;
    state == seq_idle && advance && mode == sequence_mode_code_a |=> state == seq_step ##1 RUN_LED;
  endproperty
  a_step_led: assert property (p_step_led) else $error("single step light missing");

  property p_cycle_end;
    state == seq_run && mode == sequence_mode_code_b && expire && last_loc
      && !start_event && !mode_switch |=> state == seq_idle ##1 !RUN_LED;
  endproperty
  a_cycle_end: assert property (p_cycle_end) else $error("single cycle did not end");

  property p_halt_hold;
    state == seq_run && start_event |=> state == seq_idle && $stable(loc);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt moved location");

  property p_resume;
    state == seq_idle && start_event && !mode_switch && mode != sequence_mode_code_a
      |=> state == seq_run && loc == $past(next_loc);
  endproperty
  a_resume: assert property (p_resume) else $error("resume not at next location");

  property p_cont_key;
    cmd_cont && !w_mode && state == seq_idle && !start_event
      |=> mode == sequence_mode_code_c && state == seq_idle;
  endproperty
  a_cont_key: assert property (p_cont_key) else $error("continuous key misbehaved");

  property p_standby;
    !operate |=> VOLTAGE_OUT == 16'h0 && CURRENT_OUT == 16'h0;
  endproperty
  a_standby: assert property (p_standby) else $error("output during standby");

  property p_quadrant;
    SOURCE_QUADRANT == ($past(vneg_sync) == $past(ineg_sync));
  endproperty
  a_quadrant: assert property (p_quadrant) else $error("quadrant wrong");

  property p_key_pulse;
    key_pulse |-> key_stable && !$past(key_stable) ##1 !key_pulse;
  endproperty
  a_key_pulse: assert property (p_key_pulse) else $error("key pulse too long");

  property p_dwell_min;
    WR_STROBE && ADDR == ADDR_DWELL && WR_DATA != 32'h0 && !advance
      |=> cur.dwell >= 20'(DWELL_MIN_MS);
  endproperty
  a_dwell_min: assert property (p_dwell_min) else $error("dwell below minimum");

  property p_cv_step;
    state == seq_idle ##1 state == seq_step;
  endproperty
  c_step: cover property (p_cv_step);

  property p_cv_cycle_end;
    state == seq_run && mode == sequence_mode_code_b ##1 state == seq_idle;
  endproperty
  c_cycle_end: cover property (p_cv_cycle_end);

  property p_cv_wrap;
    state == seq_run && mode == sequence_mode_code_c && loc != LOC_FIRST ##1 loc == LOC_FIRST;
  endproperty
  c_wrap: cover property (p_cv_wrap);

endmodule

//--- shared/seq_pkg.sv
package seq_pkg;
  localparam int             LOC_COUNT     = 100;
  localparam logic [6:0]     LOC_FIRST     = 7'h01;
  localparam logic [6:0]     LOC_LAST      = 7'h64;
  // Register offsets
  localparam logic [7:0]     ADDR_MODE     = 8'h00;
  localparam logic [7:0]     ADDR_LOC      = 8'h04;
  localparam logic [7:0]     ADDR_VOLT     = 8'h08;
  localparam logic [7:0]     ADDR_CURR     = 8'h0C;
  localparam logic [7:0]     ADDR_DWELL    = 8'h10;
  localparam logic [7:0]     ADDR_FLAGS    = 8'h14;
  localparam logic [7:0]     ADDR_STATUS   = 8'h18;
  localparam logic [7:0]     ADDR_CMD      = 8'h1C;
  // Field positions
  localparam int             MODE_OPERATE  = 2;
  localparam int             MODE_TALK     = 3;
  localparam int             FLAG_MOD_V    = 0;
  localparam int             FLAG_MOD_I    = 1;
  localparam int             FLAG_SINK     = 2;
  localparam int             CMD_RUN       = 0;
  localparam int             CMD_CONT      = 1;
  // Timing
  localparam int             CLK_PERIOD_NS = 10;
  localparam int             TICK_NS       = 1_000_000;
  localparam int             TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int             DEBOUNCE_NS   = 5_000_000;
  localparam int             DEBOUNCE_CYCLES = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam int             DWELL_MIN_MS  = 20;
  localparam int             DWELL_MAX_MS  = 1_000_000;
  localparam int             DWELL_COARSE_MS = 100_000;
  localparam int             DWELL_COARSE_STEP_MS = 1000;

  typedef enum logic [1:0] {
    sequence_mode_code_a = 2'h0,
    sequence_mode_code_b = 2'h1,
    sequence_mode_code_c = 2'h2
  } mode_type;

  typedef enum logic [2:0] {
    seq_idle = 3'b001,
    seq_step = 3'b010,
    seq_run  = 3'b100
  } state_type;

  typedef struct packed {
    logic signed [15:0] voltage;
    logic signed [15:0] current;
    logic [19:0]        dwell;
    logic               mod_v;
    logic               mod_i;
    logic               sink;
  } location_type;
endpackage

//--- test/panel_bus_model.sv
`timescale 1ns/100ps
module panel_bus_model (
  input  wire logic clk,
  output logic      run_key,
  output logic      ext_trigger,
  output logic      talk_addressed
);
  initial begin
    run_key = 1'b0;
    ext_trigger = 1'b0;
    talk_addressed = 1'b0;
  end
  // Key held for n cycles, longer than the debounce window
  task automatic press(input int n);
    @(posedge clk);
    run_key <= 1'b1;
    repeat (n) @(posedge clk);
    run_key <= 1'b0;
  endtask
  task automatic trig();
    @(posedge clk);
    ext_trigger <= 1'b1;
    repeat (4) @(posedge clk);
    ext_trigger <= 1'b0;
  endtask
  // Controller addresses the device to talk, then releases it
  task automatic talk();
    @(posedge clk);
    talk_addressed <= 1'b1;
    repeat (4) @(posedge clk);
    talk_addressed <= 1'b0;
  endtask
endmodule

//--- test/memory_location_sequencer_tb.sv
`timescale 1ns/100ps
module memory_location_sequencer_tb;
  import seq_pkg::*;
  logic        clk, sys_rst, wr_strobe, rd_strobe, run_key, ext_trigger, talk_addressed;
  logic        v_negative, i_negative, mod_v_led, mod_i_led, sink_led, run_led, source_quadrant;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data;
  logic [15:0] voltage_out, current_out;
  logic [6:0]  active_location;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] dw_in [4] = '{32'h5, 32'h18894, 32'hFFFFF, 32'h1869F};
  logic [31:0] dw_out [4] = '{32'h14, 32'h186A0, 32'hF4240, 32'h1869F};

  memory_location_sequencer #(.TICK_CYCLES_P(4), .DEBOUNCE_CYCLES_P(3)) i_dut (
    .CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .WR_DATA(wr_data), .WR_STROBE(wr_strobe),
    .RD_STROBE(rd_strobe), .RD_DATA(rd_data), .RUN_KEY(run_key), .EXT_TRIGGER(ext_trigger),
    .TALK_ADDRESSED(talk_addressed), .V_NEGATIVE(v_negative), .I_NEGATIVE(i_negative),
    .VOLTAGE_OUT(voltage_out), .CURRENT_OUT(current_out), .MOD_V_LED(mod_v_led),
    .MOD_I_LED(mod_i_led), .SINK_LED(sink_led), .RUN_LED(run_led),
    .SOURCE_QUADRANT(source_quadrant), .ACTIVE_LOCATION(active_location));

  panel_bus_model i_pm (.clk(clk), .run_key(run_key), .ext_trigger(ext_trigger),
    .talk_addressed(talk_addressed));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    @(negedge clk);
    chk(w, e, rd_data);
  endtask
  // Bounded wait for the sequencer to reach a location
  task automatic wait_loc(input logic [6:0] e, input int n);
    @(negedge clk);
    for (int i = 0; i < n && active_location !== e; i++) @(negedge clk);
    chk("active_location", 32'(e), 32'(active_location));
  endtask
  task automatic prog(input logic [6:0] l, input logic [15:0] v, input logic [31:0] d,
                      input logic [2:0] f);
    wr(ADDR_LOC, 32'(l));
    wr(ADDR_VOLT, {{16{v[15]}}, v});
    wr(ADDR_CURR, {{16{v[15]}}, v});
    wr(ADDR_DWELL, d);
    wr(ADDR_FLAGS, 32'(f));
  endtask
  task automatic leds(input logic [3:0] e);
    repeat (3) @(negedge clk);
    chk("leds", 32'(e), 32'({run_led, sink_led, mod_i_led, mod_v_led}));
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    {sys_rst, wr_strobe, rd_strobe, v_negative, i_negative} = 5'h10;
    addr = 8'h00;
    wr_data = 32'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("active_location", 32'h1, 32'(active_location));
    chk("leds", 32'h0, 32'({run_led, sink_led, mod_i_led, mod_v_led}));
    $display("test reset done");
    prog(7'h01, 16'h0064, 32'h14, 3'h1);
    prog(7'h02, 16'hFF38, 32'h14, 3'h6);
    prog(7'h03, 16'h03E8, 32'h14, 3'h0);
    prog(7'h04, 16'h0001, 32'h0, 3'h0);
    wr(ADDR_LOC, 32'h64);
    rd(ADDR_LOC, 32'h64, "loc");
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_DWELL, dw_in[k]);
      rd(ADDR_DWELL, dw_out[k], "dwell");
    end
    wr(ADDR_LOC, 32'h65);
    rd(ADDR_LOC, 32'h64, "loc");
    rd(8'h20, 32'h0, "unmapped");
    wr(ADDR_LOC, 32'h2);
    leds(4'h6);
    chk("volt_standby", 32'h0, 32'(voltage_out));
    wr(ADDR_MODE, 32'h4);
    leds(4'h6);
    chk("volt_operate", 32'hFF38, 32'(voltage_out));
    chk("curr_operate", 32'hFF38, 32'(current_out));
    rd(ADDR_VOLT, 32'hFFFFFF38, "volt");
    rd(ADDR_CURR, 32'hFFFFFF38, "curr");
    rd(ADDR_FLAGS, 32'h6, "flags");
    wr(ADDR_LOC, 32'h1);
    leds(4'h1);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      v_negative <= k[0];
      i_negative <= k[1];
      repeat (6) @(negedge clk);
      chk("source_quadrant", 32'(k[0] == k[1]), 32'(source_quadrant));
    end
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_MODE, 32'(k) | 32'h4);
      rd(ADDR_MODE, 32'(k) | 32'h4, "mode");
    end
    wr(ADDR_MODE, 32'h7);
    rd(ADDR_MODE, 32'h6, "mode");
    $display("test registers done");
    wr(ADDR_MODE, 32'h4);
    wr(ADDR_CMD, 32'h1);
    wait_loc(7'h02, 6);
    repeat (50) @(negedge clk);
    leds(4'hE);
    repeat (50) @(negedge clk);
    leds(4'h6);
    i_pm.press(20);
    wait_loc(7'h03, 40);
    repeat (40) @(negedge clk);
    wait_loc(7'h03, 1);
    wr(ADDR_CMD, 32'h1);
    wait_loc(7'h01, 6);
    repeat (120) @(negedge clk);
    $display("test single step done");
    wr(ADDR_MODE, 32'h5);
    wr(ADDR_CMD, 32'h1);
    wait_loc(7'h02, 6);
    wait_loc(7'h03, 100);
    repeat (120) @(negedge clk);
    wait_loc(7'h03, 1);
    leds(4'h0);
    rd(ADDR_STATUS, 32'hC, "status");
    $display("test single cycle done");
    wr(ADDR_CMD, 32'h2);
    rd(ADDR_MODE, 32'h6, "mode");
    leds(4'h0);
    wr(ADDR_MODE, 32'hE);
    i_pm.press(12);
    wait_loc(7'h01, 30);
    wait_loc(7'h02, 100);
    wait_loc(7'h03, 100);
    wait_loc(7'h01, 100);
    i_pm.trig();
    repeat (200) @(negedge clk);
    wait_loc(7'h01, 1);
    leds(4'h1);
    i_pm.talk();
    wait_loc(7'h02, 12);
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_STATUS, 32'hC, "status");
    $display("test continuous done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wait_loc(7'h01, 1);
    rd(ADDR_VOLT, 32'h64, "volt_kept");
    rd(ADDR_DWELL, 32'h14, "dwell_kept");
    $display("test reset retention done");
    close_out();
  end
endmodule
